// file: rtl/cvp_timing.sv
`timescale 1ns/1ns
module cvp_timing
  import cvp_pkg::*;
#(
  parameter int unsigned LINE_TOTAL = DEF_LINE_TOTAL,
  parameter int unsigned FRAME_TOTAL = DEF_FRAME_TOTAL
) (
  input wire logic clk,
  input wire logic rst_n,
  cvp_timing_if.gen tif
);

  localparam logic [9:0] LAST_COL = 10'(LINE_TOTAL - 1);
  localparam logic [9:0] LAST_ROW = 10'(FRAME_TOTAL - 1);

  generate
    if (LINE_TOTAL > MAX_TOTAL || LINE_TOTAL < int'(HSYNC_END)) begin : g_bad_line
      $error("line total out of range");
    end
    if (FRAME_TOTAL > MAX_TOTAL || FRAME_TOTAL < int'(VSYNC_END)) begin : g_bad_frame
      $error("frame total out of range");
    end
  endgenerate

  logic [9:0] col_q;
  logic [9:0] row_q;
  logic [10:0] hend;
  logic [10:0] vend;

  ////////////////////////////////////////////////////////////////////////////
  // free running raster, fixed whatever the window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_q <= 10'h000;
      row_q <= 10'h000;
    end else if (tif.restart) begin
      col_q <= 10'h000;
      row_q <= 10'h000;
    end else if (tif.pix_tick) begin
      if (col_q == LAST_COL) begin
        col_q <= 10'h000;
        row_q <= (row_q == LAST_ROW) ? 10'h000 : row_q + 10'h001;
      end else begin
        col_q <= col_q + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window compare and sync decode
  assign hend = {1'b0, tif.hstart} + {1'b0, tif.hsize};
  assign vend = {1'b0, tif.vstart} + {1'b0, tif.vsize};
  // (RULE_16) window gates line valid
  assign tif.line_valid = (col_q >= tif.hstart) && ({1'b0, col_q} < hend) &&
                          (row_q >= tif.vstart) && ({1'b0, row_q} < vend);
  assign tif.hsync = (col_q >= HSYNC_BEGIN) && (col_q < HSYNC_END);
  // (RULE_21) one pulse per frame
  assign tif.vsync = (row_q >= VSYNC_BEGIN) && (row_q < VSYNC_END);

endmodule // cvp_timing

// file: rtl/cvp_video_port.sv
`timescale 1ns/1ns
// Notes on behaviour
// (RULE_01) chroma pins 2..0 latched at power-up as format straps, then driven.
// (RULE_02) luma pins 7..2 and 0 latched at power-up as straps, then driven.
// (RULE_03) pixel clock and composite sync pins latched at power-up; sync pin selects monochrome.
// (RULE_04) separate 8-bit luma and chroma buses; chroma absent in monochrome.
// (RULE_05) slave select low gives one fixed id, high one of eight ids.
// (RULE_06) luma and raw colour black level is code 16.
// (RULE_07) peak white is clamped to code 240.
// (RULE_08) colour difference black level is code 128.
// (RULE_09) raw colour samples always stay between codes 16 and 240.
// (RULE_10) codes 0 and 255 never appear as pixel data; in 4-bit mode code 0 appears on luma data.
// (RULE_11) sampling runs synchronous to the pixel rate.
// (RULE_12) two 8-bit channels sampled in parallel, chroma channel shared.
// (RULE_13) output stream is 16, 8 or 4 bits wide by selection.
// (RULE_14) window from 2x2 up to 356x292 anywhere inside the array.
// (RULE_15) window changes keep frame and pixel rate unchanged.
// (RULE_16) line valid only inside programmed horizontal and vertical window.
// (RULE_17) window is 352 by 288 after reset.
// (RULE_18) receiver captures 16-bit data on rising pixel clock.
// (RULE_19) video port gives vsync, composite hsync, pixel clock and 16-bit data.
// (RULE_20) pixel clock is half the system clock.
// (RULE_21) one vertical sync pulse per frame.
// (RULE_22) line valid high only during horizontal window of valid data.
// (RULE_23) sync and data launched with pixel clock, sampled by receiver on it.
// (RULE_24) chip reset pin is active high, low means normal operation.
// (RULE_25) receiver ignores data while line valid is low.
module cvp_video_port
  import cvp_pkg::*;
#(
  parameter int unsigned LINE_TOTAL = DEF_LINE_TOTAL,
  parameter int unsigned FRAME_TOTAL = DEF_FRAME_TOTAL,
  // arbitrary value
  parameter logic [6:0] SLAVE_ID_BASE = 7'h2A
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CHIP_RESET,
  input wire logic MULTI_SLAVE_SELECT,
  input wire logic [7:0] SAMPLE_LUMA,
  input wire logic [7:0] SAMPLE_CHROMA,
  output logic SAMPLE_REQ,
  input wire logic [7:0] LUMA_LEVEL,
  output logic [7:0] LUMA_DATA,
  output logic LUMA_EN,
  input wire logic [7:0] CHROMA_LEVEL,
  output logic [7:0] CHROMA_DATA,
  output logic CHROMA_EN,
  input wire logic PCLK_LEVEL,
  output logic PCLK,
  output logic PCLK_EN,
  input wire logic CSYNC_LEVEL,
  output logic CSYNC,
  output logic CSYNC_EN,
  output logic VSYNC,
  output logic LINE_VALID,
  output logic [6:0] SLAVE_ID
);

  generate
    if (PCLK_DIV != 2) begin : g_bad_div
      $error("pixel clock divider must be two");
    end
  endgenerate

  cvp_timing_if tif ();

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [19:0] pin_raw;
  logic [19:0] sync1_q;
  logic [19:0] sync2_q;
  logic chip_rst;
  logic multi_sel;

  assign pin_raw = {CHIP_RESET, MULTI_SLAVE_SELECT, CSYNC_LEVEL, PCLK_LEVEL, CHROMA_LEVEL, LUMA_LEVEL};

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= 20'h00000;
      sync2_q <= 20'h00000;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // (RULE_24) active high chip reset
  assign chip_rst = sync2_q[19];
  assign multi_sel = sync2_q[18];

  ////////////////////////////////////////////////////////////////////////////
  // power-up strap capture
  cvp_strap_state_t strap_state_q;
  logic [1:0] settle_q;
  logic [7:0] luma_strap_q;
  logic [2:0] chroma_strap_q;
  logic pclk_strap_q;
  logic mono_strap_q;
  logic drive_q;
  logic run;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      strap_state_q <= STRAP_WAIT;
      settle_q <= 2'h0;
    end else begin
      case (strap_state_q)
        STRAP_WAIT: begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == STRAP_SETTLE) begin
            strap_state_q <= STRAP_TAKE;
          end
        end
        STRAP_TAKE: begin
          strap_state_q <= STRAP_RUN;
        end
        STRAP_RUN: begin
          strap_state_q <= STRAP_RUN;
        end
        default: begin
          strap_state_q <= STRAP_WAIT;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      luma_strap_q <= 8'h00;
      chroma_strap_q <= 3'h0;
      pclk_strap_q <= 1'b0;
      mono_strap_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (strap_state_q == STRAP_TAKE) begin
      // (RULE_02) luma straps taken
      luma_strap_q <= sync2_q[7:0] & LUMA_STRAP_MASK;
      // (RULE_01) chroma straps taken
      chroma_strap_q <= sync2_q[10:8];
      // (RULE_03) clock and sync straps
      pclk_strap_q <= sync2_q[16];
      mono_strap_q <= sync2_q[17];
      drive_q <= 1'b1;
    end
  end

  assign run = (strap_state_q == STRAP_RUN) && !chip_rst;

  ////////////////////////////////////////////////////////////////////////////
  // register file over apb
  cvp_width_t width_q;
  logic [2:0] slave_idx_q;
  logic [9:0] hstart_q;
  logic [9:0] hsize_q;
  logic [9:0] vstart_q;
  logic [9:0] vsize_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rdata_d;
  logic err_d;
  logic setup;
  logic commit;
  logic [9:0] wr_start;
  logic [9:0] wr_size;

  function automatic logic win_ok(input logic [9:0] start, input logic [9:0] size, input logic [9:0] limit);
    logic [10:0] sum;
    sum = {1'b0, start} + {1'b0, size};
    return (size >= WIN_MIN) && (sum <= {1'b0, limit});
  endfunction

  assign setup = PSEL && !PENABLE;
  assign commit = PSEL && PENABLE && pready_q && PWRITE && !pslverr_q;
  assign wr_start = PWDATA[WIN_START_LSB +: 10];
  assign wr_size = PWDATA[WIN_SIZE_LSB +: 10];

  always_comb begin
    rdata_d = 32'h00000000;
    err_d = 1'b0;
    case (PADDR)
      ADDR_CTRL: begin
        case (width_q)
          CVP_W8: rdata_d[CTRL_WIDTH_LSB +: 2] = WCODE_8;
          CVP_W4: rdata_d[CTRL_WIDTH_LSB +: 2] = WCODE_4;
          default: rdata_d[CTRL_WIDTH_LSB +: 2] = WCODE_16;
        endcase
        rdata_d[CTRL_SLAVE_LSB +: 3] = slave_idx_q;
        err_d = PWRITE && (PWDATA[CTRL_WIDTH_LSB +: 2] == 2'h3);
      end
      ADDR_HWIN: begin
        rdata_d[WIN_START_LSB +: 10] = hstart_q;
        rdata_d[WIN_SIZE_LSB +: 10] = hsize_q;
        // (RULE_14) horizontal window bounds
        err_d = PWRITE && !win_ok(wr_start, wr_size, ARRAY_W);
      end
      ADDR_VWIN: begin
        rdata_d[WIN_START_LSB +: 10] = vstart_q;
        rdata_d[WIN_SIZE_LSB +: 10] = vsize_q;
        // (RULE_14) vertical window bounds
        err_d = PWRITE && !win_ok(wr_start, wr_size, ARRAY_H);
      end
      ADDR_STRAP: begin
        rdata_d[STRAP_LUMA_LSB +: 8] = luma_strap_q;
        rdata_d[STRAP_CHROMA_LSB +: 3] = chroma_strap_q;
        rdata_d[STRAP_PCLK_BIT] = pclk_strap_q;
        rdata_d[STRAP_MONO_BIT] = mono_strap_q;
        rdata_d[STRAP_MULTI_BIT] = multi_sel;
        err_d = PWRITE;
      end
      ADDR_SLAVE: begin
        rdata_d[6:0] = SLAVE_ID;
        err_d = PWRITE;
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (setup && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= err_d;
      prdata_q <= (PWRITE || err_d) ? 32'h00000000 : rdata_d;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      width_q <= CVP_W16;
      slave_idx_q <= 3'h0;
      hstart_q <= DEF_HSTART;
      hsize_q <= DEF_HSIZE;
      vstart_q <= DEF_VSTART;
      vsize_q <= DEF_VSIZE;
    end else if (chip_rst) begin
      // (RULE_17) default window restored
      width_q <= CVP_W16;
      slave_idx_q <= 3'h0;
      hstart_q <= DEF_HSTART;
      hsize_q <= DEF_HSIZE;
      vstart_q <= DEF_VSTART;
      vsize_q <= DEF_VSIZE;
    end else if (commit) begin
      case (PADDR)
        ADDR_CTRL: begin
          // (RULE_13) stream width select
          case (PWDATA[CTRL_WIDTH_LSB +: 2])
            WCODE_8: width_q <= CVP_W8;
            WCODE_4: width_q <= CVP_W4;
            default: width_q <= CVP_W16;
          endcase
          slave_idx_q <= PWDATA[CTRL_SLAVE_LSB +: 3];
        end
        ADDR_HWIN: begin
          hstart_q <= wr_start;
          hsize_q <= wr_size;
        end
        ADDR_VWIN: begin
          vstart_q <= wr_start;
          vsize_q <= wr_size;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave identifier
  logic [6:0] slave_id_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      slave_id_q <= SLAVE_ID_BASE;
    end else begin
      // (RULE_05) single or multiple ids
      slave_id_q <= multi_sel ? SLAVE_ID_BASE + {4'h0, slave_idx_q} : SLAVE_ID_BASE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel clock and byte phase
  logic pclk_q;
  logic [1:0] phase_q;
  logic [1:0] last_phase;
  logic launch;
  logic pix_start;
  logic pix_tick;

  always_comb begin
    case (width_q)
      CVP_W8: last_phase = 2'h1;
      CVP_W4: last_phase = 2'h3;
      default: last_phase = 2'h0;
    endcase
  end

  // (RULE_20) half rate pixel clock
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pclk_q <= 1'b0;
    end else begin
      pclk_q <= run && !pclk_q;
    end
  end

  // (RULE_23) launch on falling pixel clock
  assign launch = run && pclk_q;
  assign pix_start = launch && (phase_q == 2'h0);
  assign pix_tick = launch && (phase_q == last_phase);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      phase_q <= 2'h0;
    end else if (!run || pix_tick) begin
      phase_q <= 2'h0;
    end else if (launch) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // (RULE_15) raster independent of window
  assign tif.pix_tick = pix_tick;
  assign tif.restart = !run;
  assign tif.hstart = hstart_q;
  assign tif.hsize = hsize_q;
  assign tif.vstart = vstart_q;
  assign tif.vsize = vsize_q;

  cvp_timing #(
    .LINE_TOTAL(LINE_TOTAL),
    .FRAME_TOTAL(FRAME_TOTAL)
  ) u_timing (
    .clk(CLOCK),
    .rst_n(RST_N),
    .tif(tif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sample clamp and formatting
  logic [7:0] pix_y_q;
  logic [7:0] pix_c_q;
  logic [7:0] cur_y;
  logic [7:0] cur_c;
  logic [7:0] luma_d;

  // (RULE_07) white clamp 240
  // (RULE_10) flag codes excluded
  function automatic logic [7:0] clamp_code(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v < CODE_BLACK) begin
      r = CODE_BLACK;
    end else if (v > CODE_WHITE) begin
      r = CODE_WHITE;
    end
    return r;
  endfunction

  // (RULE_12) both channels taken together
  always_comb begin
    cur_y = pix_y_q;
    cur_c = pix_c_q;
    if (pix_start) begin
      // (RULE_09) clamp to 16..240
      cur_y = tif.line_valid ? clamp_code(SAMPLE_LUMA) : CODE_BLACK;
      // (RULE_08) chroma black level
      cur_c = tif.line_valid ? clamp_code(SAMPLE_CHROMA) : CODE_CHROMA_BLACK;
    end
  end

  always_comb begin
    case (width_q)
      CVP_W8: luma_d = (phase_q == 2'h0) ? cur_c : cur_y;
      CVP_W4: begin
        case (phase_q)
          2'h0: luma_d = {cur_c[7:4], 4'h0};
          2'h1: luma_d = {cur_c[3:0], 4'h0};
          2'h2: luma_d = {cur_y[7:4], 4'h0};
          default: luma_d = {cur_y[3:0], 4'h0};
        endcase
      end
      default: luma_d = cur_y;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pix_y_q <= CODE_BLACK;
      pix_c_q <= CODE_CHROMA_BLACK;
    end else if (pix_start) begin
      pix_y_q <= cur_y;
      pix_c_q <= cur_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers
  logic [7:0] luma_q;
  logic [7:0] chroma_q;
  logic line_valid_q;
  logic vsync_q;
  logic csync_q;
  logic sample_req_q;
  logic luma_en_q;
  logic chroma_en_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      luma_q <= CODE_BLACK;
      chroma_q <= CODE_CHROMA_BLACK;
    end else if (launch) begin
      // (RULE_06) black and white limits held in 16 and 8 bit modes only
      luma_q <= luma_d;
      chroma_q <= (width_q == CVP_W16) ? cur_c : CODE_CHROMA_BLACK;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      line_valid_q <= 1'b0;
      vsync_q <= 1'b0;
      csync_q <= 1'b0;
    end else if (!run) begin
      line_valid_q <= 1'b0;
      vsync_q <= 1'b0;
      csync_q <= 1'b0;
    end else if (pix_start) begin
      // (RULE_22) valid only in window
      line_valid_q <= tif.line_valid;
      // (RULE_19) vertical and composite sync
      vsync_q <= tif.vsync;
      csync_q <= tif.hsync || tif.vsync;
    end
  end

  // (RULE_11) one request per pixel
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sample_req_q <= 1'b0;
    end else begin
      sample_req_q <= pix_start;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      luma_en_q <= 1'b0;
      chroma_en_q <= 1'b0;
    end else begin
      luma_en_q <= drive_q;
      // (RULE_04) no chroma in monochrome
      chroma_en_q <= drive_q && !mono_strap_q && (width_q == CVP_W16);
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign SAMPLE_REQ = sample_req_q;
  assign LUMA_DATA = luma_q;
  assign LUMA_EN = luma_en_q;
  assign CHROMA_DATA = chroma_q;
  assign CHROMA_EN = chroma_en_q;
  assign PCLK = pclk_q;
  assign PCLK_EN = luma_en_q;
  assign CSYNC = csync_q;
  assign CSYNC_EN = luma_en_q;
  assign VSYNC = vsync_q;
  assign LINE_VALID = line_valid_q;
  assign SLAVE_ID = slave_id_q;

endmodule // cvp_video_port

// file: shared/cvp_pkg.sv
package cvp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // array and window geometry
  localparam logic [9:0] ARRAY_W = 10'h164;
  localparam logic [9:0] ARRAY_H = 10'h124;
  localparam logic [9:0] WIN_MIN = 10'h002;
  localparam logic [9:0] DEF_HSTART = 10'h002;
  localparam logic [9:0] DEF_VSTART = 10'h002;
  localparam logic [9:0] DEF_HSIZE = 10'h160;
  localparam logic [9:0] DEF_VSIZE = 10'h120;

  ////////////////////////////////////////////////////////////////////////////
  // line and frame timing, in pixel periods and lines
  localparam int unsigned DEF_LINE_TOTAL = 420;
  localparam int unsigned DEF_FRAME_TOTAL = 312;
  localparam int unsigned MAX_TOTAL = 1023;
  localparam logic [9:0] HSYNC_BEGIN = 10'h16C;
  localparam logic [9:0] HSYNC_END = 10'h18C;
  localparam logic [9:0] VSYNC_BEGIN = 10'h126;
  localparam logic [9:0] VSYNC_END = 10'h129;
  localparam int unsigned PCLK_DIV = 2;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // output code levels
  localparam logic [7:0] CODE_BLACK = 8'h10;
  localparam logic [7:0] CODE_WHITE = 8'hF0;
  localparam logic [7:0] CODE_CHROMA_BLACK = 8'h80;
  localparam logic [7:0] LUMA_STRAP_MASK = 8'hFD;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HWIN = 8'h04;
  localparam logic [7:0] ADDR_VWIN = 8'h08;
  localparam logic [7:0] ADDR_STRAP = 8'h0C;
  localparam logic [7:0] ADDR_SLAVE = 8'h10;
  localparam int unsigned CTRL_WIDTH_LSB = 0;
  localparam int unsigned CTRL_SLAVE_LSB = 4;
  localparam int unsigned WIN_START_LSB = 0;
  localparam int unsigned WIN_SIZE_LSB = 16;
  localparam int unsigned STRAP_LUMA_LSB = 0;
  localparam int unsigned STRAP_CHROMA_LSB = 8;
  localparam int unsigned STRAP_PCLK_BIT = 11;
  localparam int unsigned STRAP_MONO_BIT = 12;
  localparam int unsigned STRAP_MULTI_BIT = 13;
  localparam logic [1:0] WCODE_16 = 2'h0;
  localparam logic [1:0] WCODE_8 = 2'h1;
  localparam logic [1:0] WCODE_4 = 2'h2;

  typedef enum logic [2:0] {
    CVP_W16 = 3'b001,
    CVP_W8 = 3'b010,
    CVP_W4 = 3'b100
  } cvp_width_t;

  typedef enum logic [2:0] {
    STRAP_WAIT = 3'b001,
    STRAP_TAKE = 3'b010,
    STRAP_RUN = 3'b100
  } cvp_strap_state_t;

endpackage

// file: shared/cvp_timing_if.sv
`timescale 1ns/1ns
interface cvp_timing_if;
  logic pix_tick;
  logic restart;
  logic [9:0] hstart;
  logic [9:0] hsize;
  logic [9:0] vstart;
  logic [9:0] vsize;
  logic line_valid;
  logic hsync;
  logic vsync;

  modport gen (
    input pix_tick, restart, hstart, hsize, vstart, vsize,
    output line_valid, hsync, vsync
  );

  modport ctl (
    output pix_tick, restart, hstart, hsize, vstart, vsize,
    input line_valid, hsync, vsync
  );
endinterface

// file: test/cvp_capture_model.sv
`timescale 1ns/1ns
module cvp_capture_model (
  input wire logic pclk,
  input wire logic line_valid,
  input wire logic drive_en,
  input wire logic chroma_en,
  input wire logic [7:0] luma_data,
  input wire logic [7:0] chroma_data,
  input wire logic csync,
  input wire logic [7:0] luma_strap,
  input wire logic [7:0] chroma_strap,
  input wire logic pclk_strap,
  input wire logic csync_strap,
  output logic [7:0] luma_lvl,
  output logic [7:0] chroma_lvl,
  output logic pclk_lvl,
  output logic csync_lvl,
  output int line_px,
  output logic line_tgl
);
  int cnt = 0;
  initial line_tgl = 1'b0;
  // strap levels until the port drives
  assign luma_lvl = drive_en ? luma_data : luma_strap;
  assign chroma_lvl = chroma_en ? chroma_data : (drive_en ? ~chroma_strap : chroma_strap);
  assign pclk_lvl = drive_en ? pclk : pclk_strap;
  assign csync_lvl = drive_en ? csync : csync_strap;
  ////////////////////////////////////////////////////////////////////////////
  // capture on rising pclk
  always @(posedge pclk) begin
    if (line_valid) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      line_px <= cnt;
      cnt <= 0;
      line_tgl <= ~line_tgl;
    end
  end
endmodule // cvp_capture_model

// file: test/cvp_video_port_checker.sv
`timescale 1ns/1ns
module cvp_video_port_checker
  import cvp_pkg::*;
#(
  parameter logic [6:0] SLAVE_ID_BASE = 7'h2A
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CHIP_RESET,
  input wire logic MULTI_SLAVE_SELECT,
  input wire logic SAMPLE_REQ,
  input wire logic [7:0] LUMA_DATA,
  input wire logic [7:0] CHROMA_DATA,
  input wire logic CHROMA_EN,
  input wire logic PCLK,
  input wire logic CSYNC,
  input wire logic VSYNC,
  input wire logic LINE_VALID,
  input wire logic [6:0] SLAVE_ID
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  a_pclk_half: assert property (PCLK |=> !PCLK) else $error("pclk high twice");
  a_pclk_run: assert property (disable iff (!RST_N || CHIP_RESET) $fell(PCLK) |=> PCLK)
    else $error("pclk stalled");
  a_launch_edge: assert property (disable iff (!RST_N || CHIP_RESET)
    !$fell(PCLK) |-> $stable(LINE_VALID) && $stable(CSYNC) && $stable(LUMA_DATA))
    else $error("video moved off pclk fall");
  a_chroma_range: assert property (CHROMA_EN |-> CHROMA_DATA inside {[8'h10:8'hF0]})
    else $error("chroma code out of range");
  a_luma_range: assert property (CHROMA_EN |-> LUMA_DATA inside {[8'h10:8'hF0]})
    else $error("luma code out of range");
  a_no_flag: assert property (LUMA_DATA != 8'hFF) else $error("flag code on luma");
  a_sync_blank: assert property (CSYNC |-> !LINE_VALID) else $error("line valid in sync");
  a_vsync_comp: assert property (VSYNC |-> CSYNC) else $error("vsync missing in csync");
  a_req_pulse: assert property (SAMPLE_REQ |=> !SAMPLE_REQ) else $error("sample request too long");
  a_slave_base: assert property (!MULTI_SLAVE_SELECT [*4] |-> SLAVE_ID == SLAVE_ID_BASE)
    else $error("slave id not base");
endmodule // cvp_video_port_checker

bind cvp_video_port cvp_video_port_checker #(.SLAVE_ID_BASE(SLAVE_ID_BASE)) cvp_video_port_checker_inst (
  .CLOCK, .RST_N, .CHIP_RESET, .MULTI_SLAVE_SELECT, .SAMPLE_REQ, .LUMA_DATA, .CHROMA_DATA,
  .CHROMA_EN, .PCLK, .CSYNC, .VSYNC, .LINE_VALID, .SLAVE_ID
);

// file: test/tb_cvp_video_port.sv
`timescale 1ns/1ns
module tb_cvp_video_port;
  import cvp_pkg::*;
  localparam logic [6:0] BASE = 7'h2A;
  localparam logic [32:0] OK = 33'h0;
  localparam logic [32:0] BAD = {1'b1, 32'h0};
  logic CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, CHIP_RESET = 0, MULTI_SLAVE_SELECT = 0;
  logic [7:0] PADDR = 0, SAMPLE_LUMA = 0, SAMPLE_CHROMA = 0, LUMA_LEVEL, CHROMA_LEVEL, LUMA_DATA, CHROMA_DATA;
  logic [31:0] PWDATA = 0, PRDATA;
  logic PREADY, PSLVERR, SAMPLE_REQ, LUMA_EN, CHROMA_EN, PCLK, PCLK_EN, CSYNC, CSYNC_EN, VSYNC, LINE_VALID;
  logic PCLK_LEVEL, CSYNC_LEVEL, tgl, pstrap, sstrap;
  logic [7:0] lstrap, cstrap;
  logic [6:0] SLAVE_ID;
  logic [9:0] s, z;
  int px, err_count = 0, tests_run = 0;
  logic [32:0] aq[$];
  int lq[$];

  cvp_video_port #(.LINE_TOTAL(396), .FRAME_TOTAL(297), .SLAVE_ID_BASE(BASE)) cvp_video_port_inst (.*);
  cvp_capture_model cvp_capture_model_inst (.pclk(PCLK), .line_valid(LINE_VALID), .drive_en(LUMA_EN),
    .chroma_en(CHROMA_EN), .luma_data(LUMA_DATA), .chroma_data(CHROMA_DATA), .csync(CSYNC),
    .luma_strap(lstrap), .chroma_strap(cstrap), .pclk_strap(pstrap), .csync_strap(sstrap),
    .luma_lvl(LUMA_LEVEL), .chroma_lvl(CHROMA_LEVEL), .pclk_lvl(PCLK_LEVEL), .csync_lvl(CSYNC_LEVEL),
    .line_px(px), .line_tgl(tgl));

  always #50 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    SAMPLE_LUMA <= 8'($urandom);
    SAMPLE_CHROMA <= 8'($urandom);
  end
  ////////////////////////////////////////////////////////////////////////////
  // result watchers
  always @(posedge CLOCK) begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1 && aq.size() > 0) check({PSLVERR, PRDATA}, aq.pop_front());
  end
  always @(tgl) begin
    if (lq.size() > 0) check(33'(px), 33'(lq.pop_front()));
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] win(input logic [9:0] st, input logic [9:0] sz);
    return {6'h00, sz, 6'h00, st};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    aq.push_back(e);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK);
      if (PREADY === 1'b1) break;
    end
    if (n >= 50) begin
      err_count++;
      end_sim();
    end
  endtask
  task automatic idle;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic line(input int w);
    int n;
    logic t;
    t = tgl;
    for (n = 0; tgl === t && n < 30000; n++) @(posedge CLOCK);
    lq.push_back(w);
    for (; lq.size() > 0 && n < 40000; n++) @(posedge CLOCK);
    if (n >= 40000) begin
      err_count++;
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    lstrap = 8'($urandom(32'h13DA));
    cstrap = 8'($urandom);
    pstrap = 1'($urandom);
    sstrap = 1'b0;
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (8) @(posedge CLOCK);
    apb(1'b0, ADDR_HWIN, 32'h0, {1'b0, win(DEF_HSTART, DEF_HSIZE)});
    apb(1'b0, ADDR_VWIN, 32'h0, {1'b0, win(DEF_VSTART, DEF_VSIZE)});
    apb(1'b0, ADDR_STRAP, 32'h0, {20'h0, sstrap, pstrap, cstrap[2:0], lstrap & LUMA_STRAP_MASK});
    apb(1'b0, ADDR_SLAVE, 32'h0, {26'h0, BASE});
    idle;
    line(352);
    $display("reset test done");
    apb(1'b1, ADDR_CTRL, 32'h3, BAD);
    apb(1'b1, ADDR_HWIN, win(10'h163, 10'h002), BAD);
    apb(1'b1, ADDR_HWIN, win(10'h000, 10'h001), BAD);
    apb(1'b1, ADDR_STRAP, 32'h0, BAD);
    apb(1'b0, 8'h14, 32'h0, BAD);
    apb(1'b0, ADDR_CTRL, 32'h0, OK);
    apb(1'b1, ADDR_VWIN, win(10'h000, 10'h124), OK);
    apb(1'b1, ADDR_HWIN, win(10'h162, 10'h002), OK);
    idle;
    line(2);
    $display("window test done");
    MULTI_SLAVE_SELECT <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h50, OK);
    idle;
    repeat (4) @(posedge CLOCK);
    apb(1'b0, ADDR_SLAVE, 32'h0, {26'h0, BASE + 7'h05});
    idle;
    $display("slave test done");
    CHIP_RESET <= 1'b1;
    repeat (6) @(posedge CLOCK);
    CHIP_RESET <= 1'b0;
    repeat (4) @(posedge CLOCK);
    apb(1'b0, ADDR_CTRL, 32'h0, OK);
    apb(1'b0, ADDR_HWIN, 32'h0, {1'b0, win(DEF_HSTART, DEF_HSIZE)});
    idle;
    $display("chip reset test done");
    for (int i = 1; i < 3; i++) begin
      z = 10'($urandom_range(356, 2));
      s = 10'($urandom_range(356 - int'(z), 0));
      apb(1'b1, ADDR_HWIN, win(s, z), OK);
      apb(1'b1, ADDR_CTRL, 32'(32'h50 | i), OK);
      apb(1'b0, ADDR_CTRL, 32'h0, {1'b0, 32'(32'h50 | i)});
      idle;
      line(int'(z) << i);
      $display("width test done");
    end
    end_sim();
  end
endmodule // tb_cvp_video_port
